// ### verilog/ssppin_consts.svh
// constants for the serial port pin interface block
`ifndef SSPPIN_CONSTS_SVH
`define SSPPIN_CONSTS_SVH
// ==========================================================
// register offsets
`define SSPPIN_OFS_FUNC 4'h0
`define SSPPIN_OFS_DIR 4'h1
`define SSPPIN_OFS_GPOUT 4'h2
`define SSPPIN_OFS_GPIN 4'h3
`define SSPPIN_OFS_CTRL 4'h4
`define SSPPIN_OFS_TXDATA 4'h5
`define SSPPIN_OFS_RXDATA 4'h6
`define SSPPIN_OFS_STAT 4'h7
// ==========================================================
// pin bit positions in function, direction and gpio registers
`define SSPPIN_B_CTL0 0
`define SSPPIN_B_CTL1 1
`define SSPPIN_B_FS 2
`define SSPPIN_B_CK 3
`define SSPPIN_B_RXD 4
`define SSPPIN_B_TXD 5
// ==========================================================
// control register fields
`define SSPPIN_C_EN 0
`define SSPPIN_C_ASYNC 1
`define SSPPIN_C_CKOUT 2
`define SSPPIN_C_FSOUT 3
`define SSPPIN_C_RCKOUT 4
// ==========================================================
// reset values and timing
`define SSPPIN_RST_FUNC 6'h00
`define SSPPIN_RST_DIR 6'h00
`define SSPPIN_RST_CTRL 5'h00
`define SSPPIN_WORD_BITS 8
`define SSPPIN_HALF_BIT_NS 32
`define SSPPIN_CLK_NS 8
`define SSPPIN_HALF_CYC ((`SSPPIN_HALF_BIT_NS) / (`SSPPIN_CLK_NS))
`endif

// ### verilog/ssppin_pkg.sv
// types for the serial port pin interface block
package ssppin_pkg;
  typedef logic [7:0] ssppin_word_t;
  typedef enum logic [1:0] {
    SSPPIN_IDLE = 2'b00,
    SSPPIN_SHIFT = 2'b01,
    SSPPIN_DONE = 2'b10
  } ssppin_state_t;
endpackage

// ### verilog/ssppin_if.sv
// bundle between pin mux and serial shifter
`timescale 1ns/100ps
interface ssppin_if;
  logic tx_clk_fall;
  logic rx_clk_rise;
  logic tx_fs;
  logic rx_fs;
  logic rx_bit;
  logic tx_bit;
  logic enable;
  logic start;
  ssppin_pkg::ssppin_word_t tx_word;
  ssppin_pkg::ssppin_word_t rx_word;
  logic rx_done;
  logic tx_done;
  modport shifter (input tx_clk_fall, rx_clk_rise, tx_fs, rx_fs, rx_bit,
    enable, tx_word, start, output tx_bit, rx_word, rx_done, tx_done);
  modport mux (output tx_clk_fall, rx_clk_rise, tx_fs, rx_fs, rx_bit,
    enable, tx_word, start, input tx_bit, rx_word, rx_done, tx_done);
endinterface

// ### verilog/ssppin_shift.sv
// transmit and receive shift registers of the serial port
`timescale 1ns/100ps
`include "ssppin_consts.svh"
module ssppin_shift (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // link to pin mux
  ssppin_if.shifter sp
);
  ssppin_pkg::ssppin_word_t tx_sr_ff, nxt_tx_sr;
  ssppin_pkg::ssppin_word_t rx_sr_ff, nxt_rx_sr;
  ssppin_pkg::ssppin_word_t rx_word_ff, nxt_rx_word;
  logic [3:0] tx_cnt_ff, nxt_tx_cnt;
  logic [3:0] rx_cnt_ff, nxt_rx_cnt;
  logic tx_bit_ff, nxt_tx_bit;
  logic rx_done_ff, nxt_rx_done;
  logic tx_done_ff, nxt_tx_done;
  logic tx_arm_ff, nxt_tx_arm;
  ssppin_pkg::ssppin_state_t st_ff, nxt_st;

  assign sp.tx_bit = tx_bit_ff;
  assign sp.rx_word = rx_word_ff;
  assign sp.rx_done = rx_done_ff;
  assign sp.tx_done = tx_done_ff;

  // ==========================================================
  // shifting; data change on falling edge, sampled on rising
  always_comb begin
    nxt_tx_sr = tx_sr_ff;
    nxt_rx_sr = rx_sr_ff;
    nxt_rx_word = rx_word_ff;
    nxt_tx_cnt = tx_cnt_ff;
    nxt_rx_cnt = rx_cnt_ff;
    nxt_tx_bit = tx_bit_ff;
    nxt_rx_done = 1'b0;
    nxt_tx_done = 1'b0;
    nxt_tx_arm = tx_arm_ff | sp.start;
    nxt_st = st_ff;
    if (!sp.enable) begin
      nxt_st = ssppin_pkg::SSPPIN_IDLE;
      nxt_tx_cnt = 4'h0;
      nxt_rx_cnt = 4'h0;
      nxt_tx_arm = 1'b0;
    end else begin
      case (st_ff)
        ssppin_pkg::SSPPIN_IDLE: begin
          // frame sync starts a transmit word when data is armed
          if (sp.tx_fs && sp.tx_clk_fall && nxt_tx_arm) begin
            nxt_tx_sr = {sp.tx_word[6:0], 1'b0};
            nxt_tx_bit = sp.tx_word[7];
            nxt_tx_cnt = 4'h1;
            nxt_tx_arm = 1'b0;
            nxt_st = ssppin_pkg::SSPPIN_SHIFT;
          end
        end
        ssppin_pkg::SSPPIN_SHIFT: begin
          if (sp.tx_clk_fall) begin
            if (tx_cnt_ff == 4'(`SSPPIN_WORD_BITS)) begin
              nxt_st = ssppin_pkg::SSPPIN_DONE;
            end else begin
              nxt_tx_bit = tx_sr_ff[7];
              nxt_tx_sr = {tx_sr_ff[6:0], 1'b0};
              nxt_tx_cnt = tx_cnt_ff + 4'h1;
            end
          end
        end
        ssppin_pkg::SSPPIN_DONE: begin
          nxt_tx_done = 1'b1;
          nxt_tx_cnt = 4'h0;
          nxt_st = ssppin_pkg::SSPPIN_IDLE;
        end
        default: nxt_st = ssppin_pkg::SSPPIN_IDLE;
      endcase
      // receiver framed by its own sync, clocked by its own clock
      if (sp.rx_clk_rise) begin
        if (rx_cnt_ff == 4'h0) begin
          if (sp.rx_fs) begin
            nxt_rx_sr = {rx_sr_ff[6:0], sp.rx_bit};
            nxt_rx_cnt = 4'h1;
          end
        end else begin
          nxt_rx_sr = {rx_sr_ff[6:0], sp.rx_bit};
          nxt_rx_cnt = rx_cnt_ff + 4'h1;
          if (rx_cnt_ff == 4'(`SSPPIN_WORD_BITS - 1)) begin
            nxt_rx_word = {rx_sr_ff[6:0], sp.rx_bit};
            nxt_rx_done = 1'b1;
            nxt_rx_cnt = 4'h0;
          end
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      tx_sr_ff <= 8'h00;
      rx_sr_ff <= 8'h00;
      rx_word_ff <= 8'h00;
      tx_cnt_ff <= 4'h0;
      rx_cnt_ff <= 4'h0;
      tx_bit_ff <= 1'b0;
      rx_done_ff <= 1'b0;
      tx_done_ff <= 1'b0;
      tx_arm_ff <= 1'b0;
      st_ff <= ssppin_pkg::SSPPIN_IDLE;
    end else begin
      tx_sr_ff <= nxt_tx_sr;
      rx_sr_ff <= nxt_rx_sr;
      rx_word_ff <= nxt_rx_word;
      tx_cnt_ff <= nxt_tx_cnt;
      rx_cnt_ff <= nxt_rx_cnt;
      tx_bit_ff <= nxt_tx_bit;
      rx_done_ff <= nxt_rx_done;
      tx_done_ff <= nxt_tx_done;
      tx_arm_ff <= nxt_tx_arm;
      st_ff <= nxt_st;
    end
  end
endmodule

// ### verilog/ssppin_top.sv
// pin interface of one synchronous serial port with gpio fallback
// ==========================================================
`timescale 1ns/100ps
`include "ssppin_consts.svh"
module ssppin_top (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // pins: input, output, output enable (low = driving)
  input wire logic [5:0] pin_in,
  output logic [5:0] pin_out,
  output logic [5:0] pin_oe_n
);
  ssppin_if sp ();

  logic [5:0] func_ff, nxt_func;
  logic [5:0] dir_ff, nxt_dir;
  logic [5:0] gpout_ff, nxt_gpout;
  logic [4:0] ctrl_ff, nxt_ctrl;
  ssppin_pkg::ssppin_word_t txd_ff, nxt_txd;
  logic start_ff, nxt_start;
  logic rx_full_ff, nxt_rx_full;
  logic tx_busy_ff, nxt_tx_busy;
  logic [7:0] rdata_ff, nxt_rdata;
  logic [5:0] sync1_ff, sync2_ff, prev_ff;
  logic [5:0] pout_ff, nxt_pout;
  logic [5:0] poe_n_ff, nxt_poe_n;
  logic [2:0] div_ff, nxt_div;
  logic gclk_ff, nxt_gclk;
  logic [3:0] fs_cnt_ff, nxt_fs_cnt;
  logic gfs_ff, nxt_gfs;
  logic gfall;
  logic grise;
  logic en;
  logic async_m;
  logic tx_clk_v, tx_clk_p, rx_clk_v;

  // serial role only when port enabled and function bit set
  function automatic logic serial_sel(input logic [5:0] f, input logic e, input int b);
    serial_sel = e & f[b];
  endfunction

  // ==========================================================
  // pin synchronisers; stage two and its delayed copy prev_ff feed logic
  always_ff @(posedge clk) begin
    if (!nrst) begin
      sync1_ff <= 6'h00;
      sync2_ff <= 6'h00;
      prev_ff <= 6'h00;
    end else begin
      sync1_ff <= pin_in;
      sync2_ff <= sync1_ff;
      prev_ff <= sync2_ff;
    end
  end

  assign en = ctrl_ff[`SSPPIN_C_EN];
  assign async_m = ctrl_ff[`SSPPIN_C_ASYNC];

  // ==========================================================
  // internal bit clock and frame sync generator
  always_comb begin
    nxt_div = div_ff + 3'h1;
    nxt_gclk = gclk_ff;
    nxt_fs_cnt = fs_cnt_ff;
    nxt_gfs = gfs_ff;
    if (!en) begin
      nxt_div = 3'h0;
      nxt_gclk = 1'b0;
      nxt_fs_cnt = 4'h0;
      nxt_gfs = 1'b0;
    end else if (div_ff == 3'(`SSPPIN_HALF_CYC - 1)) begin
      nxt_div = 3'h0;
      nxt_gclk = ~gclk_ff;
      if (gclk_ff) begin
        // frame sync high for one bit at each word start
        nxt_gfs = (fs_cnt_ff == 4'h0);
        nxt_fs_cnt = (fs_cnt_ff == 4'(`SSPPIN_WORD_BITS - 1)) ? 4'h0 : fs_cnt_ff + 4'h1;
      end
    end
  end
  assign grise = en && (div_ff == 3'(`SSPPIN_HALF_CYC - 1)) && !gclk_ff;
  assign gfall = en && (div_ff == 3'(`SSPPIN_HALF_CYC - 1)) && gclk_ff;

  // ==========================================================
  // clock and frame source selection
  always_comb begin
    // external clock edges found by sampling; partner keeps 5T minimum
    tx_clk_v = sync2_ff[`SSPPIN_B_CK] & ~prev_ff[`SSPPIN_B_CK];
    tx_clk_p = ~sync2_ff[`SSPPIN_B_CK] & prev_ff[`SSPPIN_B_CK];
    if (ctrl_ff[`SSPPIN_C_CKOUT]) begin
      tx_clk_v = grise;
      tx_clk_p = gfall;
    end
    rx_clk_v = tx_clk_v;
    if (async_m) begin
      // separate receive clock on control pin zero
      rx_clk_v = ctrl_ff[`SSPPIN_C_RCKOUT] ? grise :
        (sync2_ff[`SSPPIN_B_CTL0] & ~prev_ff[`SSPPIN_B_CTL0]);
    end
  end

  assign sp.tx_clk_fall = tx_clk_p;
  assign sp.rx_clk_rise = rx_clk_v;
  // own or external frame sync for tx
  assign sp.tx_fs = ctrl_ff[`SSPPIN_C_FSOUT] ? gfs_ff : sync2_ff[`SSPPIN_B_FS];
  // rx framed by same sync only in sync mode; async rx free-runs
  assign sp.rx_fs = async_m ? 1'b1 : sp.tx_fs;
  assign sp.rx_bit = sync2_ff[`SSPPIN_B_RXD];
  assign sp.enable = en;
  assign sp.tx_word = txd_ff;
  assign sp.start = start_ff;

  ssppin_shift u_shift (
    .clk(clk),
    .nrst(nrst),
    .sp(sp.shifter)
  );

  // ==========================================================
  // pin output mux
  always_comb begin
    for (int b = 0; b < 6; b++) begin
      // gpio: direction bit high drives the pin
      nxt_pout[b] = gpout_ff[b];
      nxt_poe_n[b] = ~dir_ff[b];
    end
    if (serial_sel(func_ff, en, `SSPPIN_B_FS)) begin
      nxt_pout[`SSPPIN_B_FS] = gfs_ff;
      nxt_poe_n[`SSPPIN_B_FS] = ~ctrl_ff[`SSPPIN_C_FSOUT];
    end
    if (serial_sel(func_ff, en, `SSPPIN_B_CK)) begin
      nxt_pout[`SSPPIN_B_CK] = gclk_ff;
      nxt_poe_n[`SSPPIN_B_CK] = ~ctrl_ff[`SSPPIN_C_CKOUT];
    end
    if (serial_sel(func_ff, en, `SSPPIN_B_RXD)) begin
      nxt_pout[`SSPPIN_B_RXD] = 1'b0;
      nxt_poe_n[`SSPPIN_B_RXD] = 1'b1;
    end
    if (serial_sel(func_ff, en, `SSPPIN_B_TXD)) begin
      nxt_pout[`SSPPIN_B_TXD] = sp.tx_bit;
      nxt_poe_n[`SSPPIN_B_TXD] = 1'b0;
    end
    if (serial_sel(func_ff, en, `SSPPIN_B_CTL0) && async_m) begin
      nxt_pout[`SSPPIN_B_CTL0] = gclk_ff;
      nxt_poe_n[`SSPPIN_B_CTL0] = ~ctrl_ff[`SSPPIN_C_RCKOUT];
    end
  end

  // ==========================================================
  // register port
  always_comb begin
    nxt_func = func_ff;
    nxt_dir = dir_ff;
    nxt_gpout = gpout_ff;
    nxt_ctrl = ctrl_ff;
    nxt_txd = txd_ff;
    nxt_start = 1'b0;
    nxt_rdata = 8'h00;
    // set wins over clear
    nxt_rx_full = rx_full_ff;
    nxt_tx_busy = tx_busy_ff & ~sp.tx_done;
    if (reg_wr) begin
      case (reg_addr)
        `SSPPIN_OFS_FUNC: nxt_func = reg_wdata[5:0];
        `SSPPIN_OFS_DIR: nxt_dir = reg_wdata[5:0];
        `SSPPIN_OFS_GPOUT: nxt_gpout = reg_wdata[5:0];
        `SSPPIN_OFS_CTRL: nxt_ctrl = reg_wdata[4:0];
        `SSPPIN_OFS_TXDATA: begin
          nxt_txd = reg_wdata;
          nxt_start = 1'b1;
          nxt_tx_busy = 1'b1;
        end
        default: nxt_start = 1'b0;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        `SSPPIN_OFS_FUNC: nxt_rdata = {2'b00, func_ff};
        `SSPPIN_OFS_DIR: nxt_rdata = {2'b00, dir_ff};
        `SSPPIN_OFS_GPOUT: nxt_rdata = {2'b00, gpout_ff};
        `SSPPIN_OFS_GPIN: nxt_rdata = {2'b00, sync2_ff};
        `SSPPIN_OFS_CTRL: nxt_rdata = {3'b000, ctrl_ff};
        `SSPPIN_OFS_TXDATA: nxt_rdata = txd_ff;
        `SSPPIN_OFS_RXDATA: begin
          nxt_rdata = sp.rx_word;
          nxt_rx_full = 1'b0;
        end
        `SSPPIN_OFS_STAT: nxt_rdata = {6'h00, tx_busy_ff, rx_full_ff};
        default: nxt_rdata = 8'h00;
      endcase
    end
    if (sp.rx_done) begin
      nxt_rx_full = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      func_ff <= `SSPPIN_RST_FUNC;
      dir_ff <= `SSPPIN_RST_DIR;
      gpout_ff <= 6'h00;
      ctrl_ff <= `SSPPIN_RST_CTRL;
      txd_ff <= 8'h00;
      start_ff <= 1'b0;
      rx_full_ff <= 1'b0;
      tx_busy_ff <= 1'b0;
      rdata_ff <= 8'h00;
      div_ff <= 3'h0;
      gclk_ff <= 1'b0;
      fs_cnt_ff <= 4'h0;
      gfs_ff <= 1'b0;
      pout_ff <= 6'h00;
      poe_n_ff <= 6'h3F;
    end else begin
      func_ff <= nxt_func;
      dir_ff <= nxt_dir;
      gpout_ff <= nxt_gpout;
      ctrl_ff <= nxt_ctrl;
      txd_ff <= nxt_txd;
      start_ff <= nxt_start;
      rx_full_ff <= nxt_rx_full;
      tx_busy_ff <= nxt_tx_busy;
      rdata_ff <= nxt_rdata;
      div_ff <= nxt_div;
      gclk_ff <= nxt_gclk;
      fs_cnt_ff <= nxt_fs_cnt;
      gfs_ff <= nxt_gfs;
      pout_ff <= nxt_pout;
      poe_n_ff <= nxt_poe_n;
    end
  end

  assign reg_rdata = rdata_ff;
  assign pin_out = pout_ff;
  assign pin_oe_n = poe_n_ff;
endmodule

// ### dv/ssppin_props.sv
// concurrent checks on the pins and register port of the serial pin block
`timescale 1ns/100ps
`include "ssppin_consts.svh"
module ssppin_props (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // pins
  input wire logic [5:0] pin_in,
  input wire logic [5:0] pin_out,
  input wire logic [5:0] pin_oe_n
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  logic [5:0] fn_ff, dir_ff, go_ff, nxt_fn, nxt_dir, nxt_go;
  logic [4:0] ct_ff, nxt_ct;
  logic [5:0] oe_ff, ser_ff, gm_ff, gv_ff, nxt_oe, nxt_ser, nxt_gm;
  logic as_ff, ck_ff, nxt_as, nxt_ck;
  // ==========
  // config shadow; second stage lines up with the registered pins
  always_comb begin
    nxt_fn = fn_ff;
    nxt_dir = dir_ff;
    nxt_go = go_ff;
    nxt_ct = ct_ff;
    if (reg_wr && reg_addr == `SSPPIN_OFS_FUNC) nxt_fn = reg_wdata[5:0];
    if (reg_wr && reg_addr == `SSPPIN_OFS_DIR) nxt_dir = reg_wdata[5:0];
    if (reg_wr && reg_addr == `SSPPIN_OFS_GPOUT) nxt_go = reg_wdata[5:0];
    if (reg_wr && reg_addr == `SSPPIN_OFS_CTRL) nxt_ct = reg_wdata[4:0];
    nxt_ser = ct_ff[`SSPPIN_C_EN] ? fn_ff : 6'h00;
    nxt_as = ct_ff[`SSPPIN_C_ASYNC];
    nxt_ck = ct_ff[`SSPPIN_C_CKOUT];
    nxt_oe = ~dir_ff;
    if (nxt_ser[0] && nxt_as) nxt_oe[0] = ~ct_ff[`SSPPIN_C_RCKOUT];
    if (nxt_ser[2]) nxt_oe[2] = ~ct_ff[`SSPPIN_C_FSOUT];
    if (nxt_ser[3]) nxt_oe[3] = ~nxt_ck;
    if (nxt_ser[4]) nxt_oe[4] = 1'b1;
    if (nxt_ser[5]) nxt_oe[5] = 1'b0;
    nxt_gm = dir_ff & ~nxt_ser;
  end
  always_ff @(posedge clk) begin
    if (!nrst) begin
      {fn_ff, dir_ff, go_ff, ct_ff} <= 23'h0;
      {oe_ff, ser_ff, gm_ff, gv_ff, as_ff, ck_ff} <= {6'h3F, 20'h0};
    end else begin
      {fn_ff, dir_ff, go_ff, ct_ff} <= {nxt_fn, nxt_dir, nxt_go, nxt_ct};
      {oe_ff, ser_ff, gm_ff, gv_ff} <= {nxt_oe, nxt_ser, nxt_gm, go_ff};
      {as_ff, ck_ff} <= {nxt_as, nxt_ck};
    end
  end
  // ==========
  // properties
  sequence s_ck_high;
    $stable(pin_out[3]) [*3] ##1 $fell(pin_out[3]);
  endsequence
  // own frame sync is high for exactly one bit, two half periods
  sequence s_fs_high;
    $stable(pin_out[2]) [*7] ##1 $fell(pin_out[2]);
  endsequence
  chk_reset_hiz: assert property ($rose(nrst) |-> pin_oe_n == 6'h3F && pin_out == 6'h00)
    else $error("pins not released after reset");
  chk_gpio_dir: assert property (((pin_oe_n ^ oe_ff) & ~ser_ff) == 6'h00)
    else $error("gpio pin direction wrong");
  chk_fs_dir: assert property (ser_ff[2] |-> pin_oe_n[2] == oe_ff[2])
    else $error("frame sync direction wrong");
  chk_ck_dir: assert property (ser_ff[3] |-> pin_oe_n[3] == oe_ff[3])
    else $error("bit clock direction wrong");
  chk_data_dir: assert property (|ser_ff[5:4] |->
    ((pin_oe_n[5:4] ^ oe_ff[5:4]) & ser_ff[5:4]) == 2'b00)
    else $error("data pin direction wrong");
  chk_rclk_dir: assert property (ser_ff[0] && as_ff |-> pin_oe_n[0] == oe_ff[0])
    else $error("receive clock direction wrong");
  chk_gpio_out: assert property (|gm_ff |-> ((pin_out ^ gv_ff) & gm_ff) == 6'h00)
    else $error("gpio output level wrong");
  chk_rd_idle: assert property (!reg_rd || reg_addr > 4'h7 |=> reg_rdata == 8'h00)
    else $error("read data not idle");
  chk_ck_half: assert property ($rose(pin_out[3]) && ser_ff[3] && ck_ff |=> s_ck_high)
    else $error("bit clock half period wrong");
  chk_fs_pulse: assert property ($rose(pin_out[2]) && ser_ff[2] && !oe_ff[2]
    |=> s_fs_high) else $error("frame sync pulse not one bit long");
endmodule

// ### dv/ssppin_codec.sv
// far-side serial device: bit clock, frame sync and receive data source
`timescale 1ns/100ps
module ssppin_codec (
  // frame request
  input wire logic go,
  input wire logic [7:0] word,
  // serial lines
  output logic ck,
  output logic fs,
  output logic dat,
  input wire logic txd,
  // result
  output logic [7:0] got,
  output logic done
);
  initial begin
    ck = 1'b0;
    fs = 1'b0;
    dat = 1'b0;
    got = 8'h00;
    done = 1'b0;
  end
  // clock stands low between frames; 80 ns period keeps ten clk per bit
  always @(posedge go) begin
    done = 1'b0;
    ck = 1'b1;
    #20 fs = 1'b1;
    for (int i = 7; i >= 0; i--) begin
      #20 ck = 1'b0;
      dat = word[i];
      #40 ck = 1'b1;
      got[i] = txd;
      #20 fs = 1'b0;
    end
    #20 ck = 1'b0;
    // released line must not keep its last level
    #40 dat = ~dat;
    done = 1'b1;
  end
endmodule

// ### dv/tb_ssppin_top.sv
// self-checking bench for the serial port pin block
`timescale 1ns/100ps
`include "ssppin_consts.svh"
module tb_ssppin_top;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata, rd_v, tx;
  logic [5:0] pin_in, pin_out, pin_oe_n;
  logic [5:0] gp_ext = 6'h15;
  logic [5:0] oe_tab [4] = '{6'h3B, 6'h3F, 6'h3F, 6'h1F};
  logic go = 1'b0;
  logic [7:0] cw = 8'h00;
  logic c_ck, c_fs, c_dat, c_done;
  logic [7:0] c_got;
  int n_mismatch = 0;
  int n_tests = 0;
  int cyc = 0;
  always #4 clk = ~clk;
  assign pin_in = (pin_oe_n & {gp_ext[5], c_dat, c_ck, c_fs, gp_ext[1:0]}) | (~pin_oe_n & pin_out);
  ssppin_top dut (.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n));
  ssppin_codec partner (.go(go), .word(cw), .ck(c_ck), .fs(c_fs), .dat(c_dat),
    .txd(pin_in[5]), .got(c_got), .done(c_done));
  // ==========
  // tasks
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic rc(input logic [3:0] a, input logic [7:0] e);
    rd(a, rd_v);
    chk(rd_v, e);
  endtask
  // pins follow a write two edges later
  task automatic pc(input logic [5:0] e);
    repeat (2) @(posedge clk);
    #1 chk({2'b00, pin_oe_n}, {2'b00, e});
  endtask
  task automatic rst();
    @(posedge clk);
    nrst <= 1'b0;
    repeat (15) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    #1;
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      close_out();
    end
  end
  // ==========
  // tests
  initial begin
    rst();
    chk({2'b00, pin_oe_n}, 8'h3F);
    chk({2'b00, pin_out}, 8'h00);
    rc(`SSPPIN_OFS_FUNC, 8'h00);
    rc(`SSPPIN_OFS_CTRL, 8'h00);
    rc(4'hC, 8'h00);
    $display("test reset done");
    wr(`SSPPIN_OFS_DIR, 8'h2A);
    wr(`SSPPIN_OFS_GPOUT, 8'h3F);
    pc(6'h15);
    chk({2'b00, pin_out & 6'h2A}, 8'h2A);
    repeat (4) @(posedge clk);
    rc(`SSPPIN_OFS_GPIN, 8'h2B);
    wr(`SSPPIN_OFS_FUNC, 8'h3C);
    pc(6'h15);
    $display("test gpio done");
    wr(`SSPPIN_OFS_DIR, 8'h00);
    wr(`SSPPIN_OFS_CTRL, 8'h09);
    for (int k = 2; k < 6; k++) begin
      wr(`SSPPIN_OFS_FUNC, 8'h01 << k);
      pc(oe_tab[k-2]);
    end
    wr(`SSPPIN_OFS_FUNC, 8'h08);
    wr(`SSPPIN_OFS_CTRL, 8'h05);
    pc(6'h37);
    $display("test pin roles done");
    rst();
    wr(`SSPPIN_OFS_FUNC, 8'h01);
    wr(`SSPPIN_OFS_CTRL, 8'h13);
    pc(6'h3E);
    wr(`SSPPIN_OFS_CTRL, 8'h03);
    pc(6'h3F);
    $display("test async done");
    rst();
    wr(`SSPPIN_OFS_CTRL, 8'h01);
    wr(`SSPPIN_OFS_FUNC, 8'h3C);
    pc(6'h1F);
    for (int j = 0; j < 2; j++) begin
      tx = j ? 8'h5A : 8'hA5;
      wr(`SSPPIN_OFS_TXDATA, tx);
      cw <= tx ^ 8'h66;
      go <= 1'b1;
      @(posedge clk);
      for (int t = 0; t < 400 && c_done !== 1'b1; t++) @(posedge clk);
      go <= 1'b0;
      chk(c_got, tx);
      rc(`SSPPIN_OFS_STAT, 8'h01);
      rc(`SSPPIN_OFS_RXDATA, tx ^ 8'h66);
      rc(`SSPPIN_OFS_STAT, 8'h00);
    end
    $display("test external frame done");
    rst();
    wr(`SSPPIN_OFS_CTRL, 8'h0D);
    wr(`SSPPIN_OFS_FUNC, 8'h3C);
    pc(6'h13);
    wr(`SSPPIN_OFS_TXDATA, 8'h96);
    rd(`SSPPIN_OFS_STAT, rd_v);
    for (int t = 0; t < 100 && rd_v[1] !== 1'b0; t++) rd(`SSPPIN_OFS_STAT, rd_v);
    chk(rd_v & 8'h02, 8'h00);
    $display("test internal clock done");
    close_out();
  end
endmodule
bind ssppin_top ssppin_props chk (.clk(clk), .nrst(nrst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n));
